// file: hw/bcop_pkg.sv
package bcop_pkg;
  // Operation select codes from the decoder
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_BIT_RESET = 3'h1;
  localparam logic [2:0] OP_WATCHDOG_RESTART = 3'h2;
  localparam logic [2:0] OP_INVERT_MEMORY = 3'h3;
  localparam logic [2:0] OP_INVERT_INTO_WORKING = 3'h4;
  localparam logic [2:0] OP_BCD_ADJUST = 3'h5;
  // Decimal correction constants
  localparam logic [3:0] BCD_NIBBLE_MAX = 4'h9;
  localparam logic [3:0] BCD_NIBBLE_FIX = 4'h6;
  localparam logic [8:0] BCD_FIX_NONE = 9'h000;
  localparam logic [8:0] BCD_FIX_LOW = 9'h006;
  localparam logic [8:0] BCD_FIX_HIGH = 9'h060;
  localparam logic [8:0] BCD_FIX_BOTH = 9'h066;
  // Reset values
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
endpackage : bcop_pkg

// file: hw/bcd_adjust_unit.sv
`timescale 1ns/100ps
`default_nettype none
module bcd_adjust_unit
  import bcop_pkg::*;
(
  // Operand and flags
  input wire logic [7:0] src_in,
  input wire logic nibble_borrow_in,
  input wire logic carry_in,
  // Result
  output logic [7:0] result_out,
  output logic carry_out
);
  logic low_fix;
  logic high_fix;
  logic [8:0] fix;
  logic [8:0] sum;

  always_comb
  begin
    low_fix = (src_in[3:0] > BCD_NIBBLE_MAX) || nibble_borrow_in;
    high_fix = (src_in[7:4] > BCD_NIBBLE_MAX) || carry_in;
    // Low correction may push the high nibble past nine
    if (!high_fix && low_fix && (src_in[7:4] == BCD_NIBBLE_MAX)
        && ({1'b0, src_in[3:0]} + {1'b0, BCD_NIBBLE_FIX} > 5'h0F))
      high_fix = 1'b1;
    case ({high_fix, low_fix})
      2'b01: fix = BCD_FIX_LOW;
      2'b10: fix = BCD_FIX_HIGH;
      2'b11: fix = BCD_FIX_BOTH;
      default: fix = BCD_FIX_NONE;
    endcase
    sum = {1'b0, src_in} + fix;
    result_out = sum[7:0];
    carry_out = sum[8] || high_fix;
  end
endmodule : bcd_adjust_unit
`default_nettype wire

// file: hw/bit_clear_complement_bcd_ops.sv
`timescale 1ns/100ps
`default_nettype none
module bit_clear_complement_bcd_ops
  import bcop_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Decoder request
  input wire logic op_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic [2:0] bit_sel_in,
  // Operand from data memory and flag inputs
  input wire logic [7:0] mem_rdata_in,
  input wire logic watchdog_expired_set_in,
  input wire logic sleep_entered_set_in,
  input wire logic nibble_borrow_flag_in,
  // Data memory write
  output logic mem_we_out,
  output logic [7:0] mem_wdata_out,
  // Architectural state
  output logic [7:0] working_register_out,
  output logic zero_flag_out,
  output logic carry_flag_out,
  output logic watchdog_expired_flag_out,
  output logic sleep_entered_flag_out,
  output logic watchdog_restart_out
);
  logic [7:0] working_ff, nxt_working;
  logic [7:0] wdata_ff, nxt_wdata;
  logic we_ff, nxt_we;
  logic zero_ff, nxt_zero;
  logic carry_ff, nxt_carry;
  logic expired_ff, nxt_expired;
  logic sleep_ff, nxt_sleep;
  logic wdt_ff, nxt_wdt;
  logic [7:0] bcd_result;
  logic bcd_carry;
  logic [7:0] inv;

  bcd_adjust_unit u_bcd (
    .src_in(working_ff),
    .nibble_borrow_in(nibble_borrow_flag_in),
    .carry_in(carry_ff),
    .result_out(bcd_result),
    .carry_out(bcd_carry)
  );

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  always_comb
  begin
    inv = ~mem_rdata_in;
    nxt_working = working_ff;
    nxt_wdata = wdata_ff;
    nxt_we = 1'b0;
    nxt_zero = zero_ff;
    nxt_carry = carry_ff;
    nxt_wdt = 1'b0;
    // Hardware set wins over a restart in the same cycle
    nxt_expired = expired_ff;
    nxt_sleep = sleep_ff;
    if (op_valid_in)
    begin
      case (op_code_in)
        OP_BIT_RESET:
        begin
          nxt_wdata = mem_rdata_in & ~(8'h01 << bit_sel_in);
          nxt_we = 1'b1;
        end
        OP_WATCHDOG_RESTART:
        begin
          nxt_wdt = 1'b1;
          nxt_expired = 1'b0;
          nxt_sleep = 1'b0;
        end
        OP_INVERT_MEMORY:
        begin
          nxt_wdata = inv;
          nxt_we = 1'b1;
          nxt_zero = (inv == 8'h00);
        end
        OP_INVERT_INTO_WORKING:
        begin
          nxt_working = inv;
          nxt_zero = (inv == 8'h00);
        end
        OP_BCD_ADJUST:
        begin
          nxt_wdata = bcd_result;
          nxt_we = 1'b1;
          nxt_carry = bcd_carry;
        end
        default: ;
      endcase
    end
    if (watchdog_expired_set_in)
      nxt_expired = 1'b1;
    if (sleep_entered_set_in)
      nxt_sleep = 1'b1;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      working_ff <= WORKING_RESET;
      wdata_ff <= DATA_RESET;
      we_ff <= 1'b0;
      zero_ff <= FLAG_RESET;
      carry_ff <= FLAG_RESET;
      expired_ff <= FLAG_RESET;
      sleep_ff <= FLAG_RESET;
      wdt_ff <= 1'b0;
    end
    else
    begin
      working_ff <= nxt_working;
      wdata_ff <= nxt_wdata;
      we_ff <= nxt_we;
      zero_ff <= nxt_zero;
      carry_ff <= nxt_carry;
      expired_ff <= nxt_expired;
      sleep_ff <= nxt_sleep;
      wdt_ff <= nxt_wdt;
    end
  end

  assign mem_we_out = we_ff;
  assign mem_wdata_out = wdata_ff;
  assign working_register_out = working_ff;
  assign zero_flag_out = zero_ff;
  assign carry_flag_out = carry_ff;
  assign watchdog_expired_flag_out = expired_ff;
  assign sleep_entered_flag_out = sleep_ff;
  assign watchdog_restart_out = wdt_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence bit_req_s;
    op_valid_in && op_code_in == OP_BIT_RESET;
  endsequence

  bit_clear_a: assert property (bit_req_s |=> mem_we_out
    && mem_wdata_out[$past(bit_sel_in)] == 1'b0
    && $stable(zero_flag_out) && $stable(carry_flag_out))
    else $error("bit clear result wrong");

  wdt_restart_a: assert property (op_valid_in
    && op_code_in == OP_WATCHDOG_RESTART && !watchdog_expired_set_in
    && !sleep_entered_set_in |=> watchdog_restart_out
    && !watchdog_expired_flag_out && !sleep_entered_flag_out
    && !mem_we_out)
    else $error("watchdog restart wrong");

  invert_mem_a: assert property (op_valid_in
    && op_code_in == OP_INVERT_MEMORY |=> mem_we_out
    && mem_wdata_out == ~$past(mem_rdata_in)
    && zero_flag_out == ($past(mem_rdata_in) == 8'hFF)
    && $stable(working_register_out))
    else $error("invert in place wrong");

  invert_work_a: assert property (op_valid_in
    && op_code_in == OP_INVERT_INTO_WORKING |=> !mem_we_out
    && working_register_out == ~$past(mem_rdata_in)
    && $stable(carry_flag_out))
    else $error("invert into working wrong");

  bcd_low_a: assert property (op_valid_in
    && op_code_in == OP_BCD_ADJUST && working_ff[3:0] <= 4'h9
    && !nibble_borrow_flag_in |=>
    mem_wdata_out[3:0] == $past(working_ff[3:0]))
    else $error("low nibble changed");

  bcd_write_a: assert property (op_valid_in
    && op_code_in == OP_BCD_ADJUST |=> mem_we_out
    && $stable(working_register_out) && $stable(zero_flag_out))
    else $error("bcd write wrong");

  bcd_carry_a: assert property (op_valid_in
    && op_code_in == OP_BCD_ADJUST && working_ff[7:4] > 4'h9
    |=> carry_flag_out)
    else $error("bcd carry not set");

  idle_write_a: assert property (!op_valid_in |=> !mem_we_out)
    else $error("spurious memory write");

  sequence bcd_req_s;
    op_valid_in && op_code_in == OP_BCD_ADJUST;
  endsequence

  // Working register is held by the adjust, so the delta is the correction
  logic [7:0] bcd_delta;
  assign bcd_delta = mem_wdata_out - working_register_out;

  bit_keep_a: assert property (bit_req_s |=>
    (mem_wdata_out | (8'h01 << $past(bit_sel_in)))
    == ($past(mem_rdata_in) | (8'h01 << $past(bit_sel_in))))
    else $error("bit clear disturbed other bits");

  restart_pulse_a: assert property (!(op_valid_in
    && op_code_in == OP_WATCHDOG_RESTART) |=> !watchdog_restart_out)
    else $error("watchdog restart without request");

  invert_zero_a: assert property (op_valid_in
    && op_code_in == OP_INVERT_INTO_WORKING |=>
    zero_flag_out == ($past(mem_rdata_in) == 8'hFF))
    else $error("invert into working zero flag wrong");

  bcd_low_fix_a: assert property (op_valid_in
    && op_code_in == OP_BCD_ADJUST
    && (working_ff[3:0] > BCD_NIBBLE_MAX || nibble_borrow_flag_in) |=>
    mem_wdata_out[3:0] == $past(working_ff[3:0]) + BCD_NIBBLE_FIX)
    else $error("low nibble not corrected");

  bcd_const_a: assert property (bcd_req_s |=>
    bcd_delta inside {8'h00, 8'h06, 8'h60, 8'h66})
    else $error("bcd correction not a legal constant");

  bcd_flags_a: assert property (op_valid_in
    && op_code_in == OP_BCD_ADJUST && !watchdog_expired_set_in
    && !sleep_entered_set_in |=> $stable(watchdog_expired_flag_out)
    && $stable(sleep_entered_flag_out))
    else $error("bcd adjust changed a watchdog flag");

  carry_hold_a: assert property (op_valid_in
    && op_code_in == OP_BCD_ADJUST && carry_flag_out |=> carry_flag_out)
    else $error("bcd carry dropped");
endmodule : bit_clear_complement_bcd_ops
`default_nettype wire

// file: sim/data_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module data_mem_model (
  // Clock
  input wire logic clk_sys_in,
  // Write back from the block and preload from the bench
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  input wire logic load_in,
  input wire logic [7:0] init_in,
  // Operand
  output logic [7:0] rdata_out
);
  // One location stands in for the addressed byte
  always_ff @(posedge clk_sys_in)
  begin
    if (load_in)
      rdata_out <= init_in;
    else if (we_in)
      rdata_out <= wdata_in;
  end
endmodule : data_mem_model
`default_nettype wire

// file: sim/tb_bit_clear_complement_bcd_ops.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      $display("Error t=%0t got %h exp %h", $time, a, e); \
      mismatches++; \
    end \
  end
module tb_bit_clear_complement_bcd_ops;
  import bcop_pkg::*;
  logic clk_sys_in = 0;
  logic rstn_in = 0;
  logic op_valid_in = 0;
  logic [2:0] op_code_in = OP_NONE;
  logic [2:0] bit_sel_in = 3'h0;
  logic wd_set = 0, sl_set = 0, borrow = 0, load = 0, c = 0;
  logic [7:0] init = 8'h00;
  logic [7:0] rdata, wdata, work;
  logic we, zf, cf, wdf, slf, wdr;
  int mismatches = 0;
  int samples_checked = 0;
  bit_clear_complement_bcd_ops uut (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .bit_sel_in(bit_sel_in), .mem_rdata_in(rdata),
    .watchdog_expired_set_in(wd_set), .sleep_entered_set_in(sl_set),
    .nibble_borrow_flag_in(borrow), .mem_we_out(we), .mem_wdata_out(wdata),
    .working_register_out(work), .zero_flag_out(zf), .carry_flag_out(cf),
    .watchdog_expired_flag_out(wdf), .sleep_entered_flag_out(slf),
    .watchdog_restart_out(wdr));
  data_mem_model mem (.clk_sys_in(clk_sys_in), .we_in(we),
    .wdata_in(wdata), .load_in(load), .init_in(init), .rdata_out(rdata));
  initial
  begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic step;
    @(posedge clk_sys_in);
    #1;
  endtask : step
  // Preload the operand, then issue one request for a single cycle
  task automatic run(input logic [2:0] code, input logic [7:0] d,
    input logic [2:0] sel);
    load = 1'b1;
    init = d;
    step;
    load = 1'b0;
    op_valid_in = 1'b1;
    op_code_in = code;
    bit_sel_in = sel;
    step;
    op_valid_in = 1'b0;
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic inv_mem(input logic [7:0] d);
    run(OP_INVERT_MEMORY, d, 3'h0);
    `CHK({we, wdata, zf, work}, {1'b1, ~d, d == 8'hFF, 8'h00})
    step;
    `CHK({we, rdata}, {1'b0, ~d})
  endtask : inv_mem
  task automatic set_w(input logic [7:0] w);
    run(OP_INVERT_INTO_WORKING, ~w, 3'h0);
    `CHK({we, work, zf, cf}, {1'b0, w, w == 8'h00, c})
    step;
    `CHK(rdata, ~w)
  endtask : set_w
  task automatic bcd(input logic [7:0] w, input logic a);
    logic [8:0] t;
    logic h;
    set_w(w);
    borrow = a;
    t = {1'b0, w} + ((w[3:0] > 4'h9 || a) ? 9'h006 : 9'h000);
    h = t[8] || t[7:4] > 4'h9 || c;
    t = t + (h ? 9'h060 : 9'h000);
    c = h;
    run(OP_BCD_ADJUST, 8'h00, 3'h0);
    `CHK({we, wdata, cf, zf}, {1'b1, t[7:0], c, w == 8'h00})
    `CHK(work, w)
    step;
    `CHK(rdata, t[7:0])
    borrow = 1'b0;
  endtask : bcd
  task automatic bit_reset;
    for (int i = 0; i < 8; i++)
    begin
      run(OP_BIT_RESET, 8'hFF, i[2:0]);
      `CHK({we, wdata, zf, cf}, {1'b1, ~(8'h01 << i), 2'h1})
      step;
      `CHK(rdata, ~(8'h01 << i))
    end
  endtask : bit_reset
  task automatic wd_restart;
    wd_set = 1'b1;
    sl_set = 1'b1;
    step;
    wd_set = 1'b0;
    sl_set = 1'b0;
    `CHK({wdf, slf}, 2'h3)
    run(OP_WATCHDOG_RESTART, 8'h00, 3'h0);
    `CHK({wdr, wdf, slf, zf, cf, we}, 6'h22)
    step;
    `CHK(wdr, 1'b0)
    // A flag set in the restart cycle must survive the restart
    wd_set = 1'b1;
    run(OP_WATCHDOG_RESTART, 8'h00, 3'h0);
    wd_set = 1'b0;
    `CHK({wdr, wdf}, 2'h3)
    run(3'h6, 8'h00, 3'h0);
    `CHK({we, wdr}, 2'h0)
  endtask : wd_restart
  task automatic summarize;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    #1;
    rstn_in = 1'b1;
    inv_mem(8'h0F);
    inv_mem(8'hFF);
    bcd(8'h12, 1'b0);
    bcd(8'h19, 1'b1);
    bcd(8'h9A, 1'b0);
    bcd(8'h15, 1'b0);
    bit_reset;
    wd_restart;
    summarize;
  end
endmodule : tb_bit_clear_complement_bcd_ops
`default_nettype wire
